// >>> hw/fap_cfg.svh
// Constants for the flash access protection block
`ifndef FAP_CFG_SVH
`define FAP_CFG_SVH
`define FAP_PAGES_PER_BANK 256
`define FAP_PAGE_BYTES 2048
`define FAP_PAGE_LSB 11
`define FAP_BANK_BIT 19
`define FAP_DWORD_LSB 3
`define FAP_ADDR_W 20
`define FAP_RDP_L0 2'h0
`define FAP_RDP_L1 2'h1
`define FAP_RDP_L2 2'h2
`define FAP_WIPE_CYCLES 4
`endif

// >>> hw/fap_ecc.sv
// SEC-DED decoder for one 64-bit flash word with 8 check bits
`timescale 1ns/1ns
module fap_ecc #(
   parameter int DW = 64
) (
   input wire logic [DW-1:0] data_i,
   input wire logic [7:0] check_i,
   output logic [DW-1:0] data_o,
   output logic single_o,
   output logic double_o
);
   logic [6:0] syn;
   logic par;
   logic [DW-1:0] fix;

   // Data bits take the code positions that are not powers of two, so a flipped
   // check bit gives a power-of-two or zero syndrome and never miscorrects a data bit
   function automatic logic [6:0] code_pos(input int k);
      logic [6:0] pos;
      int n;
      pos = 7'h00;
      n = 0;
      for (int p = 3; p < 128; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (n == k) begin
               pos = 7'(p);
            end
            n++;
         end
      end
      return pos;
   endfunction

   // Syndrome: XOR of the positions of all set data bits against the stored check bits
   always_comb begin
      syn = 7'h00;
      par = ^{data_i, check_i};
      for (int k = 0; k < DW; k++) begin
         if (data_i[k]) begin
            syn = syn ^ code_pos(k);
         end
      end
      syn = syn ^ check_i[6:0];
   end

   // Flip exactly the data bit named by the syndrome
   generate
      for (genvar g = 0; g < DW; g++) begin : g_fix
         assign fix[g] = par && (syn == code_pos(g));
      end
   endgenerate

   assign data_o = data_i ^ fix;
   assign single_o = par;
   assign double_o = !par && (syn != 7'h00);
endmodule

// >>> hw/fap_pkg.sv
// Types for the flash access protection block
package fap_pkg;
   typedef enum logic [1:0] {
      FAP_M_IFETCH = 2'h0,
      FAP_M_DATA = 2'h1,
      FAP_M_DMA = 2'h2,
      FAP_M_DEBUG = 2'h3
   } fap_master_type;
   typedef enum logic [1:0] {
      FAP_OP_READ = 2'h0,
      FAP_OP_PROG = 2'h1,
      FAP_OP_ERASE = 2'h2
   } fap_op_type;
   typedef enum logic [1:0] {
      FAP_AREA_MAIN = 2'h0,
      FAP_AREA_SYS = 2'h1,
      FAP_AREA_OPT = 2'h2
   } fap_area_type;
   typedef enum logic [1:0] {
      FAP_ST_IDLE = 2'h0,
      FAP_ST_WIPE = 2'h1
   } fap_state_type;
endpackage

// >>> hw/fap_top.sv
// Flash access protection: dual-bank arbitration, readout, write and execute-only guards
`timescale 1ns/1ns
`include "fap_cfg.svh"
module fap_top
   import fap_pkg::*;
#(
   parameter int AW = `FAP_ADDR_W,
   parameter int DW = 64
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic [1:0] req_master_i,
   input wire logic [1:0] req_op_i,
   input wire logic [1:0] req_area_i,
   input wire logic [AW-1:0] req_addr_i,
   input wire logic [DW-1:0] rd_data_i,
   input wire logic [7:0] rd_check_i,
   input wire logic [1:0] bank_busy_i,
   input wire logic [1:0] level_opt_i,
   input wire logic level_load_i,
   input wire logic debug_attached_i,
   input wire logic boot_ram_i,
   input wire logic boot_loader_i,
   input wire logic boot_bank_i,
   input wire logic exec_only_erase_on_downgrade_i,
   input wire logic [7:0] wrp_start_i [4],
   input wire logic [7:0] wrp_end_i [4],
   input wire logic [AW-4:0] xo_start_i [2],
   input wire logic [AW-4:0] xo_end_i [2],
   input wire logic refused_clr_i,
   input wire logic ecc_clr_i,
   output logic grant_o,
   output logic stall_o,
   output logic bus_error_o,
   output logic [DW-1:0] rd_data_o,
   output logic [1:0] flash_op_o,
   output logic flash_bank_o,
   output logic [7:0] flash_page_o,
   output logic boot_bank_o,
   output logic [1:0] readout_protection_level_o,
   output logic debug_disable_o,
   output logic refused_flag_o,
   output logic ecc_single_o,
   output logic ecc_double_o,
   output logic [AW-1:0] ecc_addr_o,
   output logic wipe_backup_o,
   output logic wipe_parity_sram_block_o,
   output logic wipe_exec_only_o
);
   logic [1:0] lvl_r;
   fap_state_type st_r;
   logic [2:0] wcnt_r;
   logic wipe_xo_r;
   logic bank;
   logic [7:0] page;
   logic [AW-4:0] dword;
   logic intrusion;
   logic in_wrp;
   logic in_xo;
   logic deny;
   logic busy_conflict;
   logic [DW-1:0] fixed;
   logic e_single;
   logic e_double;

   assign bank = req_addr_i[`FAP_BANK_BIT];
   assign page = req_addr_i[`FAP_BANK_BIT-1:`FAP_PAGE_LSB];
   assign dword = req_addr_i[AW-1:`FAP_DWORD_LSB];

   // Any of the three intrusion paths; debug counts only while not fused off
   assign intrusion = (debug_attached_i && lvl_r != `FAP_RDP_L2)
      || boot_ram_i || boot_loader_i;

   // Write-protect window match, two per bank, page granular
   always_comb begin
      in_wrp = 1'b0;
      for (int a = 0; a < 2; a++) begin
         if (page >= wrp_start_i[2*bank+a] && page <= wrp_end_i[2*bank+a]) begin
            in_wrp = 1'b1;
         end
      end
   end

   assign in_xo = req_area_i == FAP_AREA_MAIN
      && dword >= xo_start_i[bank] && dword <= xo_end_i[bank];

   // Access decision following the level table
   always_comb begin
      deny = 1'b0;
      if (lvl_r == `FAP_RDP_L1 && intrusion && req_area_i == FAP_AREA_MAIN) begin
         deny = 1'b1;
      end
      if (req_area_i == FAP_AREA_SYS && req_op_i != FAP_OP_READ) begin
         deny = 1'b1;
      end
      if (req_area_i == FAP_AREA_OPT && lvl_r == `FAP_RDP_L2 && req_op_i != FAP_OP_READ) begin
         deny = 1'b1;
      end
      if (req_area_i == FAP_AREA_MAIN && req_op_i != FAP_OP_READ && in_wrp) begin
         deny = 1'b1;
      end
      if (in_xo && !(req_master_i == FAP_M_IFETCH && req_op_i == FAP_OP_READ)) begin
         deny = 1'b1;
      end
      if (lvl_r == `FAP_RDP_L2 && req_master_i == FAP_M_DEBUG) begin
         deny = 1'b1;
      end
      if (st_r == FAP_ST_WIPE) begin
         deny = 1'b1;
      end
   end

   // A read to the bank currently erasing/programming waits; the other bank is free
   assign busy_conflict = req_op_i == FAP_OP_READ && req_area_i == FAP_AREA_MAIN
      && bank_busy_i[bank];

   fap_ecc #(
      .DW(DW)
   ) u_ecc (
      .data_i(rd_data_i),
      .check_i(rd_check_i),
      .data_o(fixed),
      .single_o(e_single),
      .double_o(e_double)
   );

   // Protection level: loads from options, never leaves level 2
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_r <= `FAP_RDP_L0;
      end else if (level_load_i && lvl_r != `FAP_RDP_L2 && level_opt_i != 2'h3) begin
         lvl_r <= level_opt_i;
      end
   end

   // Downgrade wipe sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= FAP_ST_IDLE;
         wcnt_r <= 3'h0;
         wipe_xo_r <= 1'b0;
      end else begin
         case (st_r)
            FAP_ST_IDLE: begin
               if (level_load_i && lvl_r == `FAP_RDP_L1 && level_opt_i == `FAP_RDP_L0) begin
                  st_r <= FAP_ST_WIPE;
                  wcnt_r <= 3'(`FAP_WIPE_CYCLES - 1);
                  wipe_xo_r <= exec_only_erase_on_downgrade_i;
               end
            end
            FAP_ST_WIPE: begin
               if (wcnt_r == 3'h0) begin
                  st_r <= FAP_ST_IDLE;
                  wipe_xo_r <= 1'b0;
               end else begin
                  wcnt_r <= wcnt_r - 3'h1;
               end
            end
            default: st_r <= FAP_ST_IDLE;
         endcase
      end
   end

   // Registered wipe strobes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wipe_backup_o <= 1'b0;
         wipe_parity_sram_block_o <= 1'b0;
         wipe_exec_only_o <= 1'b0;
      end else begin
         wipe_backup_o <= st_r == FAP_ST_WIPE;
         wipe_parity_sram_block_o <= st_r == FAP_ST_WIPE;
         wipe_exec_only_o <= st_r == FAP_ST_WIPE && wipe_xo_r;
      end
   end

   // Request answer; a refused request never reaches the array
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         grant_o <= 1'b0;
         stall_o <= 1'b0;
         bus_error_o <= 1'b0;
         flash_op_o <= FAP_OP_READ;
         flash_bank_o <= 1'b0;
         flash_page_o <= 8'h00;
         rd_data_o <= '0;
      end else begin
         grant_o <= req_i && !deny && !busy_conflict;
         stall_o <= req_i && !deny && busy_conflict;
         bus_error_o <= req_i && deny;
         flash_op_o <= (req_i && !deny && !busy_conflict) ? req_op_i : FAP_OP_READ;
         flash_bank_o <= bank;
         flash_page_o <= page;
         rd_data_o <= fixed;
      end
   end

   // Sticky refusal flag; a new refusal beats the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refused_flag_o <= 1'b0;
      end else if (req_i && deny) begin
         refused_flag_o <= 1'b1;
      end else if (refused_clr_i) begin
         refused_flag_o <= 1'b0;
      end
   end

   // ECC status; data arrives with the grant, the cycle after the request, so the address is last granted one
   logic rd_pend_r;
   logic [AW-1:0] rd_addr_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= '0;
         ecc_single_o <= 1'b0;
         ecc_double_o <= 1'b0;
         ecc_addr_o <= '0;
      end else begin
         rd_pend_r <= req_i && !deny && !busy_conflict && req_op_i == FAP_OP_READ;
         rd_addr_r <= req_addr_i;
         if (rd_pend_r && (e_single || e_double)) begin
            ecc_addr_o <= rd_addr_r;
         end
         if (rd_pend_r && e_single) begin
            ecc_single_o <= 1'b1;
         end else if (ecc_clr_i) begin
            ecc_single_o <= 1'b0;
         end
         if (rd_pend_r && e_double) begin
            ecc_double_o <= 1'b1;
         end else if (ecc_clr_i) begin
            ecc_double_o <= 1'b0;
         end
      end
   end

   // Boot bank and debug fuse outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_bank_o <= 1'b0;
         readout_protection_level_o <= `FAP_RDP_L0;
         debug_disable_o <= 1'b0;
      end else begin
         boot_bank_o <= boot_bank_i;
         readout_protection_level_o <= lvl_r;
         debug_disable_o <= lvl_r == `FAP_RDP_L2;
      end
   end

   chk_lvl2_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(lvl_r) == `FAP_RDP_L2 |-> lvl_r == `FAP_RDP_L2)
      else $error("level 2 was lowered");
   chk_refuse_err: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i && deny |=> bus_error_o && !grant_o && refused_flag_o)
      else $error("refused access not flagged");
   chk_xo_fetch_only: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i && in_xo && req_master_i != FAP_M_IFETCH |=> bus_error_o)
      else $error("execute-only region reached by non-fetch");
   chk_wrp_block: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i && in_wrp && req_area_i == FAP_AREA_MAIN && req_op_i == FAP_OP_ERASE
      |=> flash_op_o == FAP_OP_READ && !grant_o)
      else $error("erase reached write-protected page");
   chk_l1_intrusion: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i && lvl_r == `FAP_RDP_L1 && boot_ram_i && req_area_i == FAP_AREA_MAIN
      |=> bus_error_o)
      else $error("level 1 intrusion reached main memory");
   chk_l0_open: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i && lvl_r == `FAP_RDP_L0 && st_r == FAP_ST_IDLE && req_area_i == FAP_AREA_MAIN
      && req_op_i == FAP_OP_READ && !in_xo && !busy_conflict |=> grant_o)
      else $error("level 0 read refused");
   chk_downgrade_wipe: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r == FAP_ST_IDLE && level_load_i && lvl_r == `FAP_RDP_L1
      && level_opt_i == `FAP_RDP_L0 |=> ##1 wipe_backup_o [*4] ##1 !wipe_backup_o)
      else $error("downgrade wipe wrong length");
   chk_sys_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i && req_area_i == FAP_AREA_SYS && req_op_i != FAP_OP_READ |=> bus_error_o)
      else $error("system memory written");
   chk_rww_stall: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i && !deny && busy_conflict |=> stall_o && !grant_o)
      else $error("read hit a busy bank");
   chk_ecc_addr: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_pend_r && e_double |=> ecc_double_o && ecc_addr_o == $past(rd_addr_r))
      else $error("ecc fail address not captured");
endmodule

// >>> sim/fap_array_model.sv
// Flash array stand-in: returns a coded word for each granted read
`timescale 1ns/1ns
module fap_array_model (
   input wire logic grant_i,
   input wire logic [63:0] pat_i,
   input wire logic [63:0] flip_i,
   input wire logic [7:0] flip_chk_i,
   output logic [63:0] data_o,
   output logic [7:0] check_o
);
   logic [7:0] chk;
   // Code position of data bit k: the k-th number from 3 upward that is no power of two
   function automatic logic [6:0] spot(input int k);
      int p;
      int left;
      p = 2;
      left = k + 1;
      while (left > 0) begin
         p++;
         if ((p & (p - 1)) != 0) begin
            left--;
         end
      end
      return 7'(p);
   endfunction
   // Check bits come from the clean word, flips model cell upsets after coding
   always_comb begin
      chk = 8'h00;
      for (int k = 0; k < 64; k++) begin
         if (pat_i[k]) chk[6:0] = chk[6:0] ^ spot(k);
      end
      chk[7] = ^{pat_i, chk[6:0]};
   end
   // Idle array shows the inverse, so a read sampled in the wrong cycle is caught
   assign data_o = grant_i ? (pat_i ^ flip_i) : ~(pat_i ^ flip_i);
   assign check_o = grant_i ? (chk ^ flip_chk_i) : ~(chk ^ flip_chk_i);
endmodule

// >>> sim/tb.sv
// Self-checking bench for the flash access protection block
`timescale 1ns/1ns
module tb;
   import fap_pkg::*;
   localparam logic [2:0] GR = 3'h1;
   localparam logic [2:0] ST = 3'h2;
   localparam logic [2:0] ER = 3'h4;
   logic clk_i = 0, rst_i = 1, req_i = 0, level_load_i = 0, refused_clr_i = 0, ecc_clr_i = 0;
   logic [1:0] req_master_i = 0, req_op_i = 0, req_area_i = 0, bank_busy_i = 0, level_opt_i = 0;
   logic [19:0] req_addr_i = 0;
   logic debug_attached_i = 0, boot_ram_i = 0, boot_loader_i = 0, boot_bank_i = 1;
   logic exec_only_erase_on_downgrade_i = 0;
   logic [7:0] wrp_start_i [4] = '{8'h04, 8'hff, 8'hff, 8'hff};
   logic [7:0] wrp_end_i [4] = '{8'h06, 8'h00, 8'h00, 8'h00};
   logic [16:0] xo_start_i [2] = '{17'h00010, 17'h1ffff};
   logic [16:0] xo_end_i [2] = '{17'h0001f, 17'h00000};
   logic [63:0] rd_data_i, rd_data_o, pat = 64'h0123_4567_89ab_cdef, flip = 0;
   logic [7:0] rd_check_i, flash_page_o, pg_s;
   logic [7:0] flip_chk = 8'h00;
   logic grant_o, stall_o, bus_error_o, flash_bank_o, boot_bank_o, debug_disable_o, bk_s;
   logic refused_flag_o, ecc_single_o, ecc_double_o;
   logic wipe_backup_o, wipe_parity_sram_block_o, wipe_exec_only_o;
   logic [1:0] flash_op_o, readout_protection_level_o, op_s;
   logic [19:0] ecc_addr_o;
   logic [2:0] r;
   int n_fail = 0, checked = 0, cb, cp, cx;

   fap_top u_dut (.clk_i, .rst_i, .req_i, .req_master_i, .req_op_i, .req_area_i,
      .req_addr_i, .rd_data_i, .rd_check_i, .bank_busy_i, .level_opt_i, .level_load_i,
      .debug_attached_i, .boot_ram_i, .boot_loader_i, .boot_bank_i,
      .exec_only_erase_on_downgrade_i, .wrp_start_i, .wrp_end_i, .xo_start_i, .xo_end_i,
      .refused_clr_i, .ecc_clr_i, .grant_o, .stall_o, .bus_error_o, .rd_data_o,
      .flash_op_o, .flash_bank_o, .flash_page_o, .boot_bank_o, .readout_protection_level_o,
      .debug_disable_o, .refused_flag_o, .ecc_single_o, .ecc_double_o, .ecc_addr_o,
      .wipe_backup_o, .wipe_parity_sram_block_o, .wipe_exec_only_o);
   fap_array_model u_mem (.grant_i(grant_o), .pat_i(pat), .flip_i(flip),
      .flip_chk_i(flip_chk), .data_o(rd_data_i), .check_o(rd_check_i));

   // Free-running system clock, 100 ns period
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   task automatic close_out;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One-cycle request pulse; answer is waited for under a small bound
   task automatic req(input logic [1:0] m, o, ar, input logic [19:0] a);
      int n;
      req_master_i = m;
      req_op_i = o;
      req_area_i = ar;
      req_addr_i = a;
      req_i = 1;
      @(negedge clk_i);
      req_i = 0;
      n = 0;
      r = {bus_error_o, stall_o, grant_o};
      while (r == 3'h0 && n < 3) begin
         @(negedge clk_i);
         r = {bus_error_o, stall_o, grant_o};
         n++;
      end
      op_s = flash_op_o;
      pg_s = flash_page_o;
      bk_s = flash_bank_o;
      if (r == 3'h0) begin
         n_fail++;
         $display("[ERR] %0t no answer to request", $time);
         close_out();
      end
      @(negedge clk_i);
   endtask

   // Level load pulse, then count wipe strobe cycles over a window
   task automatic ld(input logic [1:0] lv);
      level_opt_i = lv;
      level_load_i = 1;
      @(negedge clk_i);
      level_load_i = 0;
      cb = 0;
      cp = 0;
      cx = 0;
      repeat (10) begin
         cb += int'(wipe_backup_o);
         cp += int'(wipe_parity_sram_block_o);
         cx += int'(wipe_exec_only_o);
         @(negedge clk_i);
      end
   endtask

   task automatic t_read_ecc;
      req(FAP_M_DMA, FAP_OP_READ, FAP_AREA_MAIN, 20'h00100);
      cmp(r, GR, "level 0 read");
      cmp(rd_data_o, pat, "clean data");
      flip = 64'h0000_0000_0000_0020;
      req(FAP_M_DMA, FAP_OP_READ, FAP_AREA_MAIN, 20'h80818);
      cmp(rd_data_o, pat, "corrected data");
      cmp(ecc_single_o, 1'b1, "single flag");
      cmp(ecc_addr_o, 20'h80818, "fail address");
      ecc_clr_i = 1;
      @(negedge clk_i);
      ecc_clr_i = 0;
      flip = 64'h0000_0100_0000_0002;
      req(FAP_M_DATA, FAP_OP_READ, FAP_AREA_MAIN, 20'h00040);
      cmp(ecc_double_o, 1'b1, "double flag");
      flip = 0;
      // An upset check bit must leave the data alone and count as a single error
      ecc_clr_i = 1;
      @(negedge clk_i);
      ecc_clr_i = 0;
      flip_chk = 8'h04;
      req(FAP_M_DATA, FAP_OP_READ, FAP_AREA_MAIN, 20'h00048);
      cmp(rd_data_o, pat, "check bit upset data");
      cmp(ecc_single_o, 1'b1, "check bit upset flag");
      cmp(ecc_double_o, 1'b0, "check bit upset not double");
      flip_chk = 8'h00;
   endtask

   task automatic t_busy;
      bank_busy_i = 2'h1;
      req(FAP_M_DMA, FAP_OP_READ, FAP_AREA_MAIN, 20'h80000);
      cmp(r, GR, "read other bank");
      req(FAP_M_DMA, FAP_OP_READ, FAP_AREA_MAIN, 20'h00008);
      cmp(r, ST, "read busy bank");
      bank_busy_i = 2'h0;
   endtask

   task automatic t_wrp;
      req(FAP_M_DATA, FAP_OP_ERASE, FAP_AREA_MAIN, 20'h02800);
      cmp(r, ER, "erase in protected page");
      cmp(op_s, FAP_OP_READ, "no erase sent");
      cmp(refused_flag_o, 1'b1, "refused flag");
      refused_clr_i = 1;
      @(negedge clk_i);
      refused_clr_i = 0;
      @(negedge clk_i);
      cmp(refused_flag_o, 1'b0, "refused flag cleared");
      req(FAP_M_DATA, FAP_OP_PROG, FAP_AREA_MAIN, 20'h02000);
      cmp(r, ER, "program at range start");
      req(FAP_M_DATA, FAP_OP_ERASE, FAP_AREA_MAIN, 20'h03800);
      cmp(r, GR, "erase past range");
      cmp(op_s, FAP_OP_ERASE, "erase sent");
      cmp(pg_s, 8'h07, "erase page");
      req(FAP_M_DATA, FAP_OP_ERASE, FAP_AREA_MAIN, 20'hff800);
      cmp({bk_s, pg_s}, 9'h1ff, "last page bank 1");
   endtask

   task automatic t_xo;
      req(FAP_M_IFETCH, FAP_OP_READ, FAP_AREA_MAIN, 20'h00080);
      cmp(r, GR, "fetch in region");
      for (int m = 1; m < 4; m++) begin
         req(2'(m), FAP_OP_READ, FAP_AREA_MAIN, 20'h000f8);
         cmp(r, ER, "other master in region");
      end
      req(FAP_M_DATA, FAP_OP_PROG, FAP_AREA_MAIN, 20'h00080);
      cmp(r, ER, "write in region");
      req(FAP_M_DMA, FAP_OP_READ, FAP_AREA_MAIN, 20'h00078);
      cmp(r, GR, "dword below region");
      req(FAP_M_DMA, FAP_OP_READ, FAP_AREA_MAIN, 20'h00100);
      cmp(r, GR, "dword above region");
   endtask

   task automatic t_level1;
      ld(2'h1);
      cmp(readout_protection_level_o, 2'h1, "level 1 loaded");
      debug_attached_i = 1;
      req(FAP_M_IFETCH, FAP_OP_READ, FAP_AREA_MAIN, 20'h00200);
      cmp(r, ER, "debugger attached");
      debug_attached_i = 0;
      boot_ram_i = 1;
      req(FAP_M_DATA, FAP_OP_PROG, FAP_AREA_MAIN, 20'h00200);
      cmp(r, ER, "ram boot");
      boot_ram_i = 0;
      boot_loader_i = 1;
      req(FAP_M_DATA, FAP_OP_READ, FAP_AREA_MAIN, 20'h00200);
      cmp(r, ER, "loader boot");
      boot_loader_i = 0;
      req(FAP_M_DATA, FAP_OP_READ, FAP_AREA_MAIN, 20'h00200);
      cmp(r, GR, "user read main");
      req(FAP_M_DATA, FAP_OP_PROG, FAP_AREA_SYS, 20'h00200);
      cmp(r, ER, "system write");
      req(FAP_M_DATA, FAP_OP_PROG, FAP_AREA_OPT, 20'h00000);
      cmp(r, GR, "option write level 1");
   endtask

   task automatic t_down;
      exec_only_erase_on_downgrade_i = 1;
      ld(2'h0);
      cmp(cb, 4, "backup wipe length");
      cmp(cp, 4, "parity block wipe length");
      cmp(cx, 4, "region wipe length");
      exec_only_erase_on_downgrade_i = 0;
      ld(2'h1);
      ld(2'h0);
      cmp(cx, 0, "region kept");
      cmp(cb, 4, "backup wiped again");
   endtask

   task automatic t_level2;
      ld(2'h2);
      cmp(debug_disable_o, 1'b1, "debug disabled");
      req(FAP_M_DEBUG, FAP_OP_READ, FAP_AREA_MAIN, 20'h00200);
      cmp(r, ER, "debug read level 2");
      req(FAP_M_DATA, FAP_OP_PROG, FAP_AREA_OPT, 20'h00000);
      cmp(r, ER, "option write level 2");
      req(FAP_M_IFETCH, FAP_OP_READ, FAP_AREA_MAIN, 20'h00200);
      cmp(r, GR, "fetch level 2");
      ld(2'h0);
      ld(2'h1);
      cmp(readout_protection_level_o, 2'h2, "level 2 kept");
      cmp(cb, 0, "no wipe from level 2");
   endtask

   // Main sequence: reset, then scenarios; level 2 last since it cannot be left
   initial begin
      repeat (16) @(negedge clk_i);
      rst_i = 0;
      repeat (4) @(negedge clk_i);
      cmp(boot_bank_o, 1'b1, "boot bank");
      t_read_ecc();
      t_busy();
      t_wrp();
      t_xo();
      t_level1();
      t_down();
      t_level2();
      close_out();
   end
endmodule
